// ==== lcis_host.sv ====
// lcis_host: host end; runs the lcd bring-up sequence and single writes.
// assumes an avalon-mm master on the register side and the device at the
// far end of the link. list of behaviour kept by the two ends:
// Contract
// R1 - reset leaves control off, font bank zero; chip clear here keeps osc_on_q and contrast_q
// R2 - host waits 10 us after reset
// R3 - static display command only in standby
// R4 - init: display on, contrast zero, oscillator on
// R5 - wait 20 ms, then power control on
// R6 - then write working contrast, init done
// R7 - clear: text 20h, glyph and symbol 00h
// R8 - ram not cleared by reset, host writes it
// R9 - address setup then data writes display data
// R10 - standby release commands in any order
// R11 - device takes 80, 68 or serial writes
// R12 - select and a0 may switch apart
// R13 - reset only when pulse exceeds 10 us
//
// Implementation choices: the register offsets and the Avalon-MM slave port.
`default_nettype none
`include "lcis_map.svh"
module lcis_host #(
  parameter int PWR_WAIT_CYC = `LCIS_PWR_CYC,
  parameter int RAM_DEPTH    = `LCIS_RAM_DEPTH,
  parameter int TEXT_END     = `LCIS_TEXT_END
) (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  lcis_link_if.host                 link,
  input  wire lcis_pkg::lcis_mode_t link_mode,
  input  wire logic [1:0]           avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [31:0]          avs_writedata,
  output var  logic [31:0]          avs_readdata,
  output var  logic                 avs_waitrequest
);
  import lcis_pkg::*;

  lcis_seq_t  seq_q;
  lcis_link_t lk_q;
  logic [19:0] wt_q;
  logic [7:0]  idx_q;
  logic [9:0]  cnt_q;
  logic [2:0]  bit_q;
  logic        go_q;
  logic [8:0]  tx_q;
  logic        done_q;
  logic [3:0]  vol_q;
  logic        cs_n_q;
  logic        a0_q;
  logic        strobe_q;
  logic        clear_n_q;
  logic [7:0]  bus_q;
  logic        idle;
  logic        ready;
  logic        acc_wr;
  logic        start;
  logic        raw;
  logic        strobe_idle;

  assign link.cs_n = cs_n_q;
  assign link.cmd_data_select = a0_q;
  assign link.wr_strobe = strobe_q;
  assign link.chip_clear_in_n = clear_n_q;
  assign link.bus = bus_q;

  // fixed opening commands, indexed by step
  function automatic logic [7:0] open_cmd(input logic [2:0] i);
    case (i)
      3'h0:    return {`LCIS_OP_SYS, 4'h0};
      3'h1:    return {`LCIS_OP_DISP, 4'h1}; // R4
      3'h2:    return {`LCIS_OP_VOL, 4'h0}; // R4
      3'h3:    return {`LCIS_OP_PSAVE, 4'h1}; // R4
      default: return 8'h80; // R9
    endcase
  endfunction

  // register writes that start link traffic wait for an idle link
  assign idle = (seq_q == SQ_IDLE) && (lk_q == LK_IDLE) && !go_q;
  assign ready = !avs_write || idle ||
                 (avs_address != `LCIS_REG_CTRL && avs_address != `LCIS_REG_WRITE);
  assign acc_wr = avs_write && !avs_waitrequest;
  assign start = acc_wr && avs_address == `LCIS_REG_CTRL &&
                 avs_writedata[`LCIS_CTRL_START];
  assign raw = acc_wr && avs_address == `LCIS_REG_WRITE;
  assign strobe_idle = (link_mode != LCIS_M68);

  // avalon slave: waitrequest drops for one cycle per accepted transfer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else if ((avs_read || avs_write) && avs_waitrequest && ready) begin
      avs_waitrequest <= 1'b0;
      avs_readdata <= 32'h0000_0000;
      if (avs_read) begin
        case (avs_address)
          `LCIS_REG_STATUS: begin
            avs_readdata[`LCIS_ST_BUSY] <= !idle;
            avs_readdata[`LCIS_ST_DONE] <= done_q;
          end
          `LCIS_REG_VOL: avs_readdata[3:0] <= vol_q;
          default: avs_readdata <= 32'h0000_0000;
        endcase
      end
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  // working contrast value, kept for the last step
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vol_q <= `LCIS_VOL_RST;
    end else if (acc_wr && avs_address == `LCIS_REG_VOL) begin
      vol_q <= avs_writedata[3:0];
    end
  end

  // bring-up sequencer, hands one byte at a time to the link engine
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      seq_q <= SQ_IDLE;
      wt_q <= 20'h00000;
      idx_q <= 8'h00;
      go_q <= 1'b0;
      tx_q <= 9'h000;
      done_q <= 1'b0;
      clear_n_q <= 1'b1;
    end else begin
      go_q <= 1'b0;
      case (seq_q)
        SQ_IDLE: begin
          if (start) begin
            done_q <= 1'b0;
            clear_n_q <= 1'b0;
            wt_q <= 20'h00000;
            seq_q <= SQ_CLEAR;
          end else if (raw) begin
            go_q <= 1'b1;
            tx_q <= {avs_writedata[`LCIS_WR_A0], avs_writedata[7:0]};
            seq_q <= SQ_RAW;
          end
        end
        SQ_CLEAR: begin
          if (wt_q == 20'(`LCIS_RW_CYC + 1)) begin
            clear_n_q <= 1'b1; // R13
            wt_q <= 20'h00000;
            seq_q <= SQ_BOOT;
          end else begin
            wt_q <= wt_q + 20'h00001;
          end
        end
        SQ_BOOT: begin
          if (wt_q == 20'(`LCIS_BOOT_CYC)) begin
            idx_q <= 8'h00;
            seq_q <= SQ_CMD; // R2
          end else begin
            wt_q <= wt_q + 20'h00001;
          end
        end
        SQ_CMD: begin
          if (lk_q == LK_IDLE && !go_q) begin
            go_q <= 1'b1;
            tx_q <= {1'b0, open_cmd(idx_q[2:0])};
            idx_q <= idx_q + 8'h01;
            if (idx_q == 8'h04) begin
              idx_q <= 8'h00;
              seq_q <= SQ_FILL;
            end
          end
        end
        SQ_FILL: begin
          if (lk_q == LK_IDLE && !go_q) begin
            go_q <= 1'b1;
            tx_q <= {1'b1, (idx_q < 8'(TEXT_END)) ? `LCIS_BLANK : `LCIS_NULL}; // R7 R8
            idx_q <= idx_q + 8'h01;
            wt_q <= 20'h00000;
            if (idx_q == 8'(RAM_DEPTH - 1)) begin
              seq_q <= SQ_PWAIT;
            end
          end
        end
        SQ_PWAIT: begin
          if (lk_q == LK_IDLE && !go_q) begin
            if (wt_q == 20'(PWR_WAIT_CYC)) begin
              seq_q <= SQ_PWR; // R5
            end else begin
              wt_q <= wt_q + 20'h00001;
            end
          end
        end
        SQ_PWR: begin
          go_q <= 1'b1;
          tx_q <= {1'b0, `LCIS_OP_PWR, 4'h7}; // R5
          seq_q <= SQ_VOL;
        end
        SQ_VOL: begin
          if (lk_q == LK_IDLE && !go_q) begin
            go_q <= 1'b1;
            tx_q <= {1'b0, `LCIS_OP_VOL, vol_q}; // R6
            done_q <= 1'b1;
            seq_q <= SQ_RAW;
          end
        end
        SQ_RAW: begin
          if (lk_q == LK_IDLE && !go_q) begin
            seq_q <= SQ_IDLE;
          end
        end
        default: seq_q <= SQ_IDLE;
      endcase
    end
  end

  // link engine: one write per go, parallel strobe or 8 serial clocks
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lk_q <= LK_IDLE;
      cnt_q <= 10'h000;
      bit_q <= 3'h0;
      cs_n_q <= 1'b1;
      a0_q <= 1'b0;
      strobe_q <= 1'b1;
      bus_q <= 8'h00;
    end else begin
      case (lk_q)
        LK_IDLE: begin
          strobe_q <= strobe_idle;
          if (go_q) begin
            cs_n_q <= 1'b0;
            a0_q <= tx_q[8]; // R12
            bit_q <= 3'h7;
            lk_q <= LK_SETUP;
            if (link_mode == LCIS_SER) begin
              bus_q <= {tx_q[7], 1'b0, 6'h00};
              cnt_q <= 10'(`LCIS_CSS_CYC - 1);
            end else begin
              bus_q <= tx_q[7:0];
              cnt_q <= 10'(`LCIS_AW_CYC - 1);
            end
          end
        end
        LK_SETUP: begin
          if (cnt_q != 10'h000) begin
            cnt_q <= cnt_q - 10'h001;
          end else if (link_mode == LCIS_SER) begin
            cnt_q <= 10'(`LCIS_SHALF_CYC - 1);
            lk_q <= LK_SLOW;
          end else begin
            strobe_q <= !strobe_idle; // R11
            cnt_q <= 10'(`LCIS_CC_CYC - 1);
            lk_q <= LK_PULSE;
          end
        end
        LK_PULSE: begin
          if (cnt_q != 10'h000) begin
            cnt_q <= cnt_q - 10'h001;
          end else begin
            strobe_q <= strobe_idle;
            cnt_q <= 10'(`LCIS_DH_CYC - 1);
            lk_q <= LK_HOLD;
          end
        end
        LK_SLOW: begin
          if (cnt_q != 10'h000) begin
            cnt_q <= cnt_q - 10'h001;
          end else begin
            bus_q[6] <= 1'b1; // R11
            cnt_q <= 10'(`LCIS_SHALF_CYC - 1);
            lk_q <= LK_SHIGH;
          end
        end
        LK_SHIGH: begin
          if (cnt_q != 10'h000) begin
            cnt_q <= cnt_q - 10'h001;
          end else if (bit_q == 3'h0) begin
            cnt_q <= 10'(`LCIS_CSH_CYC - 1);
            lk_q <= LK_HOLD;
          end else begin
            bus_q <= {tx_q[bit_q - 3'h1], 1'b0, 6'h00};
            bit_q <= bit_q - 3'h1;
            cnt_q <= 10'(`LCIS_SHALF_CYC - 1);
            lk_q <= LK_SLOW;
          end
        end
        LK_HOLD: begin
          if (cnt_q != 10'h000) begin
            cnt_q <= cnt_q - 10'h001;
          end else begin
            cs_n_q <= 1'b1;
            cnt_q <= 10'(`LCIS_GAP_CYC - 1);
            lk_q <= LK_GAP;
          end
        end
        LK_GAP: begin
          if (cnt_q != 10'h000) begin
            cnt_q <= cnt_q - 10'h001;
          end else begin
            bus_q <= 8'h00;
            lk_q <= LK_IDLE;
          end
        end
        default: lk_q <= LK_IDLE;
      endcase
    end
  end
endmodule // lcis_host
`default_nettype wire

// ==== lcis_map.svh ====
// lcis_map.svh: offsets, field positions, reset values and timing counts
// of the character lcd bring-up link. included by both link ends.
`ifndef LCIS_MAP_SVH
`define LCIS_MAP_SVH

// clock rate in MHz, 40 ns period
`define LCIS_CLK_MHZ      25
// least chip clear pulse and boot wait, microseconds
`define LCIS_T_RW_US      10
`define LCIS_RW_CYC       (`LCIS_T_RW_US * `LCIS_CLK_MHZ)
`define LCIS_T_BOOT_US    10
`define LCIS_BOOT_CYC     (`LCIS_T_BOOT_US * `LCIS_CLK_MHZ)
// wait before power control, milliseconds
`define LCIS_T_PWR_MS     20
`define LCIS_PWR_CYC      (`LCIS_T_PWR_MS * 1000 * `LCIS_CLK_MHZ)
// parallel write timing, nanoseconds, rounded up to cycles
`define LCIS_T_AW_NS      60
`define LCIS_AW_CYC       ((`LCIS_T_AW_NS * `LCIS_CLK_MHZ + 999) / 1000)
`define LCIS_T_CC_NS      150
`define LCIS_CC_CYC       ((`LCIS_T_CC_NS * `LCIS_CLK_MHZ + 999) / 1000)
`define LCIS_T_DH_NS      50
`define LCIS_DH_CYC       ((`LCIS_T_DH_NS * `LCIS_CLK_MHZ + 999) / 1000)
`define LCIS_T_CYC_NS     650
`define LCIS_CYC_CYC      ((`LCIS_T_CYC_NS * `LCIS_CLK_MHZ + 999) / 1000)
`define LCIS_GAP_CYC      (`LCIS_CYC_CYC - `LCIS_AW_CYC - `LCIS_CC_CYC - `LCIS_DH_CYC)
// serial write timing
`define LCIS_T_CSS_NS     150
`define LCIS_CSS_CYC      ((`LCIS_T_CSS_NS * `LCIS_CLK_MHZ + 999) / 1000)
`define LCIS_T_SHALF_NS   500
`define LCIS_SHALF_CYC    ((`LCIS_T_SHALF_NS * `LCIS_CLK_MHZ + 999) / 1000)
`define LCIS_T_CSH_NS     700
`define LCIS_CSH_CYC      ((`LCIS_T_CSH_NS * `LCIS_CLK_MHZ + 999) / 1000)

// command opcodes, upper nibble; bit 7 set means ram address setup
`define LCIS_OP_SYS       4'h1
`define LCIS_OP_STAT      4'h2
`define LCIS_OP_DISP      4'h3
`define LCIS_OP_PSAVE     4'h4
`define LCIS_OP_PWR       4'h5
`define LCIS_OP_VOL       4'h6
`define LCIS_ADDR_BIT     7
// ram clear values and layout
`define LCIS_BLANK        8'h20
`define LCIS_NULL         8'h00
`define LCIS_RAM_DEPTH    128
`define LCIS_TEXT_END     64

// avalon word offsets and fields
`define LCIS_REG_CTRL     2'h0
`define LCIS_REG_STATUS   2'h1
`define LCIS_REG_VOL      2'h2
`define LCIS_REG_WRITE    2'h3
`define LCIS_CTRL_START   0
`define LCIS_ST_BUSY      0
`define LCIS_ST_DONE      1
`define LCIS_WR_A0        8
`define LCIS_VOL_RST      4'h8
`define LCIS_CONTRAST_RST 4'h0

`endif

// ==== lcis_pkg.sv ====
// lcis_pkg: types shared by both ends of the lcd bring-up link.
// assumes nothing beyond a systemverilog compiler.
`default_nettype none
package lcis_pkg;
  typedef enum logic [1:0] {LCIS_M80, LCIS_M68, LCIS_SER} lcis_mode_t;
  typedef enum logic [3:0] {
    SQ_IDLE, SQ_CLEAR, SQ_BOOT, SQ_CMD, SQ_FILL, SQ_PWAIT, SQ_PWR, SQ_VOL, SQ_RAW
  } lcis_seq_t;
  typedef enum logic [2:0] {
    LK_IDLE, LK_SETUP, LK_PULSE, LK_HOLD, LK_GAP, LK_SLOW, LK_SHIGH
  } lcis_link_t;
endpackage
`default_nettype wire

// ==== lcis_link_if.sv ====
// lcis_link_if: parallel/serial write link between host and lcd device.
// assumes the bench joins the two ends; in serial mode bus[6] is the
// shift clock and bus[7] the shift data.
`default_nettype none
interface lcis_link_if;
  logic       cs_n;
  logic       cmd_data_select;
  logic       wr_strobe;
  logic       chip_clear_in_n;
  logic [7:0] bus;
  modport host (output cs_n, output cmd_data_select, output wr_strobe,
                output chip_clear_in_n, output bus);
  modport dev  (input cs_n, input cmd_data_select, input wr_strobe,
                input chip_clear_in_n, input bus);
endinterface
`default_nettype wire

// ==== lcis_dev.sv ====
// lcis_dev: lcd controller end; takes write commands and ram data.
// assumes link inputs are synchronous to clk and the host keeps timing.
`default_nettype none
`include "lcis_map.svh"
module lcis_dev (
  input  wire logic               clk,
  input  wire logic               rst_n,
  lcis_link_if.dev                link,
  input  wire lcis_pkg::lcis_mode_t link_mode,
  input  wire logic [6:0]         view_addr,
  output var  logic [7:0]         view_data_q,
  output var  logic               static_display_q,
  output var  logic               display_on_q,
  output var  logic               power_save_enable_q,
  output var  logic               osc_on_q,
  output var  logic               booster_on_q,
  output var  logic               follower_enable_q,
  output var  logic               converter_enable_q,
  output var  logic               font_bank_select_q,
  output var  logic [3:0]         contrast_q,
  output var  logic               standby_q,
  output var  logic               clear_active_q
);
  import lcis_pkg::*;

  logic       strobe_p_q;
  logic       sclk_p_q;
  logic [6:0] shift_q;
  logic [2:0] bitn_q;
  logic [8:0] clr_cnt_q;
  logic [6:0] addr_q;
  logic [7:0] ram_q [`LCIS_RAM_DEPTH];
  logic       take;
  logic [7:0] take_byte;
  logic       sclk_rise;

  // opcode field of a command byte
  function automatic logic [3:0] op_of(input logic [7:0] b);
    return b[7:4];
  endfunction

  // chip clear filter: only a pulse wider than the least width resets
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clr_cnt_q <= 9'h000;
      clear_active_q <= 1'b0;
    end else if (link.chip_clear_in_n) begin
      clr_cnt_q <= 9'h000;
      clear_active_q <= 1'b0;
    end else if (clr_cnt_q == 9'(`LCIS_RW_CYC)) begin
      clear_active_q <= 1'b1; // R13
    end else begin
      clr_cnt_q <= clr_cnt_q + 9'h001;
    end
  end

  // edge history of the strobe and serial clock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strobe_p_q <= 1'b1;
      sclk_p_q <= 1'b0;
    end else begin
      strobe_p_q <= link.wr_strobe;
      sclk_p_q <= link.bus[6];
    end
  end

  assign sclk_rise = link.bus[6] && !sclk_p_q;

  // select and a0 are only looked at on the strobe edge or the eighth serial clock rise, so they may move apart
  always_comb begin
    take = 1'b0;
    take_byte = link.bus;
    if (!link.cs_n && link.chip_clear_in_n) begin
      case (link_mode)
        LCIS_M80: take = link.wr_strobe && !strobe_p_q; // R11 R12
        LCIS_M68: take = !link.wr_strobe && strobe_p_q; // R11 R12
        LCIS_SER: begin
          take = sclk_rise && (bitn_q == 3'h7); // R11
          take_byte = {shift_q, link.bus[7]};
        end
        default: take = 1'b0;
      endcase
    end
  end

  // serial shifter, msb first, restarts whenever select is high
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_q <= 7'h00;
      bitn_q <= 3'h0;
    end else if (link.cs_n || link_mode != LCIS_SER) begin
      bitn_q <= 3'h0;
    end else if (sclk_rise) begin
      shift_q <= {shift_q[5:0], link.bus[7]};
      bitn_q <= bitn_q + 3'h1;
    end
  end

  // command registers; chip clear brings back the documented start state but keeps osc_on_q and contrast_q
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      static_display_q <= 1'b0;
      display_on_q <= 1'b0;
      power_save_enable_q <= 1'b0;
      osc_on_q <= 1'b0;
      booster_on_q <= 1'b0;
      follower_enable_q <= 1'b0;
      converter_enable_q <= 1'b0;
      font_bank_select_q <= 1'b0;
      contrast_q <= `LCIS_CONTRAST_RST;
    end else if (clear_active_q) begin
      static_display_q <= 1'b0; // R1
      display_on_q <= 1'b0; // R1
      power_save_enable_q <= 1'b0; // R1
      booster_on_q <= 1'b0; // R1
      follower_enable_q <= 1'b0; // R1
      converter_enable_q <= 1'b0; // R1
      font_bank_select_q <= 1'b0; // R1
    end else if (take && !link.cmd_data_select && !take_byte[`LCIS_ADDR_BIT]) begin
      case (op_of(take_byte))
        `LCIS_OP_SYS:  font_bank_select_q <= take_byte[0];
        `LCIS_OP_STAT: if (power_save_enable_q && osc_on_q) begin
          static_display_q <= take_byte[0]; // R3
        end
        `LCIS_OP_DISP: display_on_q <= take_byte[0];
        `LCIS_OP_PSAVE: begin
          power_save_enable_q <= take_byte[1];
          osc_on_q <= take_byte[0];
        end
        `LCIS_OP_PWR: begin
          booster_on_q <= take_byte[2];
          follower_enable_q <= take_byte[1];
          converter_enable_q <= take_byte[0];
        end
        `LCIS_OP_VOL:  contrast_q <= take_byte[3:0];
        default: ;
      endcase
    end
  end

  // standby is power save with the oscillator still running
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      standby_q <= 1'b0;
    end else begin
      standby_q <= power_save_enable_q && osc_on_q;
    end
  end

  // ram address setup and auto-incrementing data writes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_q <= 7'h00;
    end else if (take && !link.cmd_data_select && take_byte[`LCIS_ADDR_BIT]) begin
      addr_q <= take_byte[6:0]; // R9
    end else if (take && link.cmd_data_select) begin
      addr_q <= addr_q + 7'h01; // R9
    end
  end

  // ram has no reset: content is unknown until the host writes it
  always_ff @(posedge clk) begin
    if (take && link.cmd_data_select) begin
      ram_q[addr_q] <= take_byte; // R8 R9
    end
    view_data_q <= ram_q[view_addr]; // R9
  end
endmodule // lcis_dev
`default_nettype wire

// ==== lcis_chk_sva.sv ====
// lcis_chk_sva: timing checks on the lcd bring-up link.
// assumes it sits beside the link interface and sees its plain signals.
`default_nettype none
module lcis_chk (
  input wire logic                 clk,
  input wire logic                 rst_n,
  input wire lcis_pkg::lcis_mode_t link_mode,
  input wire logic                 cs_n,
  input wire logic                 cmd_data_select,
  input wire logic                 wr_strobe,
  input wire logic                 chip_clear_in_n,
  input wire logic [7:0]           bus
);
  timeunit 1ns;
  timeprecision 1ps;
  import lcis_pkg::*;
  logic [9:0] low_cnt_q;
  logic [8:0] boot_cnt_q;
  logic       par;
  logic       act;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // parallel mode and the strobe level that means a write is active
  assign par = (link_mode != LCIS_SER);
  assign act = (link_mode == LCIS_M68) ? wr_strobe : !wr_strobe;
  // length of the current clear pulse, saturating
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      low_cnt_q <= 10'h000;
    else if (chip_clear_in_n)
      low_cnt_q <= 10'h000;
    else if (low_cnt_q != 10'h3FF)
      low_cnt_q <= low_cnt_q + 10'h001;
  end
  // cycles since the clear pin went high; full after plain reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      boot_cnt_q <= 9'h0FA;
    else if (!chip_clear_in_n)
      boot_cnt_q <= 9'h000;
    else if (boot_cnt_q < 9'h0FA)
      boot_cnt_q <= boot_cnt_q + 9'h001;
  end
  sequence s_setup;
    (!act) [*2] ##1 act;
  endsequence
  sequence s_pulse;
    (act && !cs_n) [*4] ##1 (!act && !cs_n);
  endsequence
  AST_CLEAR_WIDTH: assert property (
    $rose(chip_clear_in_n) |-> low_cnt_q >= 10'h0FB) else $error("clear pulse too short");
  AST_BOOT_WAIT: assert property (
    $fell(cs_n) |-> boot_cnt_q >= 9'h0F9) else $error("write too soon after clear");
  AST_NO_WR_CLEAR: assert property (
    !chip_clear_in_n |-> cs_n) else $error("write during clear");
  AST_SETUP: assert property (
    par && $fell(cs_n) |-> s_setup) else $error("select setup wrong");
  AST_PULSE: assert property (
    par && !cs_n && $rose(act) |-> s_pulse) else $error("strobe width wrong");
  AST_HOLD_ACT: assert property (
    par && act && !cs_n |=> $stable(bus) && $stable(cmd_data_select))
    else $error("data moved under strobe");
  AST_HOLD_END: assert property (
    par && !cs_n && $fell(act) |-> ($stable(bus) && !cs_n) [*2]) else $error("hold too short");
  AST_GAP: assert property (
    $rose(cs_n) |-> cs_n [*8]) else $error("gap too short");
  AST_SER_HOLD: assert property (
    !par && bus[6] && $past(bus[6]) |-> $stable(bus[7])) else $error("serial data moved");
  AST_SER_IDLE: assert property (
    !par |-> wr_strobe) else $error("strobe used in serial");
endmodule // lcis_chk
`default_nettype wire

// ==== lcis_tb.sv ====
// lcis_tb: joins host and device ends; checks bring-up and raw writes.
// assumes the design files and the link checker are compiled before it.
`default_nettype none
`include "lcis_map.svh"
module lcis_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import lcis_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n;
  lcis_mode_t  mode_r;
  logic [1:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [6:0]  view_addr;
  logic [7:0]  view_data_q;
  logic [7:0]  fl_o;
  logic [3:0]  ct_o;
  logic        sb_o;
  int          err_total;
  int          cmp_count;
  logic [7:0]  ram_m [128];
  logic [6:0]  addr_m;
  logic [7:0]  fl_m;
  logic [3:0]  ct_m;
  logic [31:0] q;
  logic [3:0]  vol;
  int          n;
  logic [7:0]  rb;
  // bring-up bytes and a raw command table covering opcodes 1 to 5, all but contrast
  logic [7:0] lcis_boot_b [5] = '{8'h10, 8'h31, 8'h60, 8'h41, 8'h80};
  logic [7:0] lcis_raw_b [8] = '{8'h21, 8'h43, 8'h21, 8'h11, 8'h50, 8'h41, 8'h20, 8'h31};
  // 25 MHz clock
  always #20 clk = ~clk;
  lcis_link_if lcis_link_if_i ();
  lcis_host #(.PWR_WAIT_CYC(200)) lcis_host_i (.clk(clk), .rst_n(rst_n),
    .link(lcis_link_if_i.host), .link_mode(mode_r), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  lcis_dev lcis_dev_i (.clk(clk), .rst_n(rst_n), .link(lcis_link_if_i.dev),
    .link_mode(mode_r), .view_addr(view_addr), .view_data_q(view_data_q),
    .static_display_q(fl_o[7]), .display_on_q(fl_o[6]), .power_save_enable_q(fl_o[5]),
    .osc_on_q(fl_o[4]), .booster_on_q(fl_o[3]), .follower_enable_q(fl_o[2]),
    .converter_enable_q(fl_o[1]), .font_bank_select_q(fl_o[0]), .contrast_q(ct_o),
    .standby_q(sb_o), .clear_active_q());
  lcis_chk lcis_chk_i (.clk(clk), .rst_n(rst_n), .link_mode(mode_r),
    .cs_n(lcis_link_if_i.cs_n), .cmd_data_select(lcis_link_if_i.cmd_data_select),
    .wr_strobe(lcis_link_if_i.wr_strobe), .chip_clear_in_n(lcis_link_if_i.chip_clear_in_n),
    .bus(lcis_link_if_i.bus));
  task automatic print_verdict();
    $display("compares %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic give_up(input int cnt);
    if (cnt >= 100000) begin
      err_total++;
      $display("unexpected at %0t: wait ran out", $time);
      print_verdict();
    end
  endtask
  // one avalon transfer, held until waitrequest is seen low
  task automatic av(input logic wr, input logic [1:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do begin
      @(posedge clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 100000);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    give_up(k);
  endtask
  // reference model of the device for one link byte
  task automatic mdl(input logic a0, input logic [7:0] b);
    if (a0) begin
      ram_m[addr_m] = b;
      addr_m = addr_m + 7'h01;
    end else if (b[7])
      addr_m = b[6:0];
    else
      case (b[7:4])
        4'h1: fl_m[0] = b[0];
        4'h2: if (fl_m[5] && fl_m[4]) fl_m[7] = b[0];
        4'h3: fl_m[6] = b[0];
        4'h4: fl_m[5:4] = b[1:0];
        4'h5: fl_m[3:1] = b[2:0];
        4'h6: ct_m = b[3:0];
        default: ;
      endcase
  endtask
  task automatic raw(input logic [7:0] b);
    av(1'b1, `LCIS_REG_WRITE, {23'h000000, 1'b0, b});
    mdl(1'b0, b);
  endtask
  // let the last serial byte land, then compare state, and the ram when ram is set
  task automatic check_all(input string what, input logic ram);
    repeat (300) @(posedge clk);
    chk({4'h0, fl_o}, {4'h0, fl_m}, what);
    chk({8'h00, ct_o}, {8'h00, ct_m}, what);
    chk({11'h000, sb_o}, {11'h000, fl_m[5] & fl_m[4]}, what);
    for (int i = 0; ram && i < 128; i++) begin
      view_addr <= i[6:0];
      repeat (2) @(posedge clk);
      chk({4'h0, view_data_q}, {4'h0, ram_m[i]}, what);
    end
    $display("test %s finished", what);
  endtask
  // reset, bring-up and raw writes in each link mode
  initial begin
    rst_n = 1'b0;
    mode_r = LCIS_M80;
    avs_address = 2'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h00000000;
    view_addr = 7'h00;
    err_total = 0;
    cmp_count = 0;
    void'($urandom(77));
    for (int m = 0; m < 3; m++) begin
      rst_n <= 1'b0;
      mode_r <= lcis_mode_t'(m);
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      fl_m = 8'h00;
      ct_m = 4'h0;
      check_all("reset", 1'b0);
      av(1'b0, `LCIS_REG_VOL, 32'h0);
      chk(q[11:0], 12'h008, "vol reset");
      av(1'b0, `LCIS_REG_STATUS, 32'h0);
      chk(q[11:0], 12'h000, "status reset");
      vol = 4'($urandom_range(15, 1));
      av(1'b1, `LCIS_REG_VOL, {28'h0000000, vol});
      av(1'b1, `LCIS_REG_CTRL, 32'h00000001);
      fl_m = fl_m & 8'h10;
      foreach (lcis_boot_b[i]) mdl(1'b0, lcis_boot_b[i]);
      for (int i = 0; i < 128; i++) mdl(1'b1, (i < 64) ? 8'h20 : 8'h00);
      mdl(1'b0, 8'h57);
      mdl(1'b0, {4'h6, vol});
      n = 0;
      do begin
        av(1'b0, `LCIS_REG_STATUS, 32'h0);
        n++;
      end while (q[1:0] !== 2'b10 && n < 20000);
      give_up(n * 5);
      check_all("bring-up", 1'b1);
      foreach (lcis_raw_b[i]) raw(lcis_raw_b[i]);
      raw({1'b1, 7'($urandom_range(127, 120))});
      // random ram data, followed by the model so the ram compare sees it
      for (int j = 0; j < 10; j++) begin
        rb = 8'($urandom);
        av(1'b1, `LCIS_REG_WRITE, {23'h0, 1'b1, rb});
        mdl(1'b1, rb);
      end
      check_all("raw", 1'b1);
    end
    print_verdict();
  end
endmodule // lcis_tb
`default_nettype wire
